// file: ata_write_regs.vh
`ifndef ATA_WRITE_REGS_VH
`define ATA_WRITE_REGS_VH

// ==========================================================
// Task-file offsets (host address lines)
`define TF_DATA 3'h0
`define TF_FEATURE_ERROR 3'h1
`define TF_SECTOR_COUNT 3'h2
`define TF_SECTOR_NUMBER 3'h3
`define TF_CYLINDER_LOW 3'h4
`define TF_CYLINDER_HIGH 3'h5
`define TF_DRIVE_HEAD 3'h6
`define TF_COMMAND_STATUS 3'h7

// ==========================================================
// Command codes
`define CMD_WRITE_A 8'h30
`define CMD_WRITE_B 8'h31
`define CMD_WRITE_NO_ERASE 8'h38
`define CMD_WRITE_VERIFY 8'h3C

// ==========================================================
// Status bit positions
`define ST_BUSY 7
`define ST_READY 6
`define ST_FAULT 5
`define ST_SEEK_DONE 4
`define ST_DATA_REQ 3
`define ST_CORRECTED 2
`define ST_SPARE 1
`define ST_ERROR 0

// ==========================================================
// Error bit masks
`define ERR_BAD_BLOCK 8'h80
`define ERR_UNCORRECTABLE 8'h40
`define ERR_ID_NOT_FOUND 8'h10
`define ERR_ABORTED 8'h04
`define ERR_MARK_NOT_FOUND 8'h01
`define ERR_WRITE_ALLOWED 8'h95

// ==========================================================
// Drive/head layout and reset values
`define DH_LBA_BIT 6
`define DH_DRIVE_BIT 4
`define DH_FIXED_ONES 8'hA0
`define RST_TASK_BYTE 8'h00
`define RST_SECTOR_COUNT 8'h01
`define RST_SECTOR_NUMBER 8'h01
`define RST_DRIVE_HEAD 8'hA0

`endif

// file: sector_buffer.v
`timescale 1ns/1ps

// ==========================================================
// Sector buffer: host fills it, media back end drains it
module sector_buffer #(
  parameter WIDTH = 16,
  parameter DEPTH = 256,
  parameter AW = 8
) (
  input wire clk_in,
  input wire ce_in,
  input wire wr_in,
  input wire [AW-1:0] waddr_in,
  input wire [WIDTH-1:0] wdata_in,
  input wire [AW-1:0] raddr_in,
  output reg [WIDTH-1:0] rdata_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Plain flops, no reset: contents are don't-care until filled
  always @(posedge clk_in) begin
    if (ce_in) begin
      if (wr_in) begin
        mem[waddr_in] <= wdata_in;
      end
      rdata_out <= mem[raddr_in];
    end
  end
endmodule // sector_buffer

// file: address_stepper.v
`timescale 1ns/1ps

// ==========================================================
// Next sector address, LBA or cylinder/head/sector
module address_stepper #(
  parameter SECTORS_PER_TRACK = 63,
  parameter HEADS = 16
) (
  input wire lba_mode_in,
  input wire [3:0] head_in,
  input wire [15:0] cylinder_in,
  input wire [7:0] sector_in,
  output reg [3:0] head_out,
  output reg [15:0] cylinder_out,
  output reg [7:0] sector_out
);
  // Parameters are cut to the field widths on purpose
  localparam [31:0] LAST_SECTOR_FULL = SECTORS_PER_TRACK;
  localparam [31:0] LAST_HEAD_FULL = HEADS - 1;
  localparam [7:0] LAST_SECTOR = LAST_SECTOR_FULL[7:0];
  localparam [3:0] LAST_HEAD = LAST_HEAD_FULL[3:0];
  reg [27:0] lba_next;

  // CHS: sector wraps to 1, then head, then cylinder carry; LBA: plain 28-bit increment
  always @* begin
    lba_next = {head_in, cylinder_in, sector_in} + 28'h000_0001;
    head_out = head_in;
    cylinder_out = cylinder_in;
    sector_out = sector_in + 8'h01;
    if (lba_mode_in) begin
      head_out = lba_next[27:24];
      cylinder_out = lba_next[23:8];
      sector_out = lba_next[7:0];
    end else if (sector_in >= LAST_SECTOR) begin
      sector_out = 8'h01;
      if (head_in >= LAST_HEAD) begin
        head_out = 4'h0;
        cylinder_out = cylinder_in + 16'h0001;
      end else begin
        head_out = head_in + 4'h1;
      end
    end
  end
endmodule // address_stepper

// file: ata_sector_write_command_engine.v
// Summary of operation
// - Command 30H or 31H starts the sector-write sequence.
// - Sector count 1 to 256; a zero count means 256 sectors.
// - Start at the addressed sector and walk consecutive sectors.
// - On accept, busy first, then data request with busy dropped.
// - No interrupt before the first sector's data request.
// - Full sector in buffer: busy set, data request cleared.
// - Buffer free for next sector: data request, busy off, interrupt.
// - After last sector stay busy until done, then clear and interrupt.
// - A write error stops the command at the failing sector.
// - On error, address registers keep the failing sector.
// - Command 38H behaves exactly like the plain sector write.
// - Command 3CH verifies each sector after writing, same handshake.
// - Drive/head: bits 7 and 5 one, bit 6 LBA, bit 4 drive.
// - LBA mode: cylinder high 23-16, low 15-8, sector number 7-0.
// - Writes report only bad block, ID, aborted, mark errors.
// - Unknown commands post only aborted, with ordinary status bits.
`timescale 1ns/1ps
`include "ata_write_regs.vh"

module ata_sector_write_command_engine #(
  parameter WORDS_PER_SECTOR = 256,
  parameter WORD_AW = 8,
  parameter SECTORS_PER_TRACK = 63,
  parameter HEADS = 16
) (
  input wire CLK_SYS_IN,
  input wire RST_B_IN,
  input wire CE_IN,
  input wire [2:0] HOST_ADDR_IN,
  input wire HOST_WR_IN,
  input wire HOST_RD_IN,
  input wire [15:0] HOST_WDATA_IN,
  output reg [15:0] HOST_RDATA_OUT,
  output reg INTRQ_OUT,
  output reg MEDIA_START_OUT,
  output reg MEDIA_VERIFY_OUT,
  output reg MEDIA_LBA_MODE_OUT,
  output reg [27:0] MEDIA_ADDR_OUT,
  input wire [WORD_AW-1:0] MEDIA_WORD_IN,
  output wire [15:0] MEDIA_DATA_OUT,
  input wire MEDIA_DONE_IN,
  input wire [7:0] MEDIA_ERROR_IN
);
  // ========================================================
  // States, one-hot
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_ACCEPT = 5'b00010;
  localparam [4:0] S_XFER = 5'b00100;
  localparam [4:0] S_MEDIA = 5'b01000;
  localparam [4:0] S_WAIT = 5'b10000;
  // Word index is narrower than the parameter; cut on purpose
  localparam [31:0] LAST_WORD_FULL = WORDS_PER_SECTOR - 1;
  localparam [WORD_AW-1:0] LAST_WORD = LAST_WORD_FULL[WORD_AW-1:0];

  // ========================================================
  // Command decode, used at accept only; verify mode is a separate compare
  function is_write_cmd;
    input [7:0] code;
    begin
      is_write_cmd = (code == `CMD_WRITE_A) || (code == `CMD_WRITE_B) ||
        (code == `CMD_WRITE_NO_ERASE) || (code == `CMD_WRITE_VERIFY);
    end
  endfunction

  // ========================================================
  // Task-file registers and sequencer state
  reg [4:0] state;
  reg [7:0] feature_param;
  reg [7:0] sector_count;
  reg [7:0] sector_number;
  reg [7:0] cylinder_low;
  reg [7:0] cylinder_high;
  reg [7:0] drive_head_select;
  reg [7:0] error_code;
  reg busy;
  reg data_req;
  reg err_flag;
  reg verify_mode;
  reg [8:0] remaining;
  reg [WORD_AW-1:0] word_idx;
  wire [3:0] step_head;
  wire [15:0] step_cyl;
  wire [7:0] step_sec;
  wire tf_write;
  wire data_write;
  wire status_read;
  wire [7:0] device_state;
  wire [7:0] write_err;
  wire [WORD_AW-1:0] next_word_idx;
  wire last_word;
  wire last_sector;

  // ========================================================
  // Host strobes; task file is frozen while busy
  assign tf_write = HOST_WR_IN && !busy && !data_req;
  assign data_write = HOST_WR_IN && data_req && (HOST_ADDR_IN == `TF_DATA);
  assign status_read = HOST_RD_IN && (HOST_ADDR_IN == `TF_COMMAND_STATUS);
  assign write_err = MEDIA_ERROR_IN & `ERR_WRITE_ALLOWED;

  // Sector progress; the index wraps to zero after the last word
  assign next_word_idx = word_idx + {{(WORD_AW-1){1'b0}}, 1'b1};
  assign last_word = (word_idx == LAST_WORD);
  assign last_sector = (remaining == 9'h001);

  // Status byte: ready and seek-complete always, corrected never
  assign device_state[`ST_BUSY] = busy;
  assign device_state[`ST_READY] = 1'b1;
  assign device_state[`ST_FAULT] = 1'b0;
  assign device_state[`ST_SEEK_DONE] = 1'b1;
  assign device_state[`ST_DATA_REQ] = data_req;
  assign device_state[`ST_CORRECTED] = 1'b0;
  assign device_state[`ST_SPARE] = 1'b0;
  assign device_state[`ST_ERROR] = err_flag;

  // ========================================================
  // Sector buffer between host and media
  sector_buffer #(
    .WIDTH(16),
    .DEPTH(WORDS_PER_SECTOR),
    .AW(WORD_AW)
  ) u_buffer (
    .clk_in(CLK_SYS_IN),
    .ce_in(CE_IN),
    .wr_in(data_write),
    .waddr_in(word_idx),
    .wdata_in(HOST_WDATA_IN),
    .raddr_in(MEDIA_WORD_IN),
    .rdata_out(MEDIA_DATA_OUT)
  );

  // Next consecutive sector address
  address_stepper #(
    .SECTORS_PER_TRACK(SECTORS_PER_TRACK),
    .HEADS(HEADS)
  ) u_stepper (
    .lba_mode_in(drive_head_select[`DH_LBA_BIT]),
    .head_in(drive_head_select[3:0]),
    .cylinder_in({cylinder_high, cylinder_low}),
    .sector_in(sector_number),
    .head_out(step_head),
    .cylinder_out(step_cyl),
    .sector_out(step_sec)
  );

  // ========================================================
  // Command sequencer and task file
  always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      // Task file to its power-on values
      state <= S_IDLE;
      feature_param <= `RST_TASK_BYTE;
      sector_count <= `RST_SECTOR_COUNT;
      sector_number <= `RST_SECTOR_NUMBER;
      cylinder_low <= `RST_TASK_BYTE;
      cylinder_high <= `RST_TASK_BYTE;
      drive_head_select <= `RST_DRIVE_HEAD;
      error_code <= `RST_TASK_BYTE;
      // Handshake and sequencing flags idle
      busy <= 1'b0;
      data_req <= 1'b0;
      err_flag <= 1'b0;
      verify_mode <= 1'b0;
      remaining <= 9'h000;
      word_idx <= {WORD_AW{1'b0}};
      // Host and media outputs quiet
      INTRQ_OUT <= 1'b0;
      MEDIA_START_OUT <= 1'b0;
      MEDIA_VERIFY_OUT <= 1'b0;
      MEDIA_LBA_MODE_OUT <= 1'b0;
      MEDIA_ADDR_OUT <= 28'h000_0000;
    end else if (CE_IN) begin
      // Start is a one-cycle pulse
      MEDIA_START_OUT <= 1'b0;
      // Reading status acknowledges the interrupt
      if (status_read) begin
        INTRQ_OUT <= 1'b0;
      end
      // Any interrupt set below overrides that clear, so a set is never lost
      case (state)
        S_IDLE: begin
          // Task file open to the host only here
          if (tf_write) begin
            case (HOST_ADDR_IN)
              `TF_FEATURE_ERROR: feature_param <= HOST_WDATA_IN[7:0];
              `TF_SECTOR_COUNT: sector_count <= HOST_WDATA_IN[7:0];
              `TF_SECTOR_NUMBER: sector_number <= HOST_WDATA_IN[7:0];
              `TF_CYLINDER_LOW: cylinder_low <= HOST_WDATA_IN[7:0];
              `TF_CYLINDER_HIGH: cylinder_high <= HOST_WDATA_IN[7:0];
              `TF_DRIVE_HEAD: drive_head_select <= HOST_WDATA_IN[7:0] | `DH_FIXED_ONES;
              `TF_COMMAND_STATUS: begin
                busy <= 1'b1;
                INTRQ_OUT <= 1'b0;
                if (is_write_cmd(HOST_WDATA_IN[7:0])) begin
                  verify_mode <= (HOST_WDATA_IN[7:0] == `CMD_WRITE_VERIFY);
                  remaining <= (sector_count == 8'h00) ? 9'h100 : {1'b0, sector_count};
                  error_code <= `RST_TASK_BYTE;
                  err_flag <= 1'b0;
                  state <= S_ACCEPT;
                end else begin
                  // Unknown code: aborted only, no media access
                  error_code <= `ERR_ABORTED;
                  err_flag <= 1'b1;
                  state <= S_WAIT;
                end
              end
              default: begin
              end
            endcase
          end
        end
        S_ACCEPT: begin
          // Busy held one cycle, then data request; no interrupt here
          busy <= 1'b0;
          data_req <= 1'b1;
          word_idx <= {WORD_AW{1'b0}};
          state <= S_XFER;
        end
        S_XFER: begin
          // One word per data write; the last word hands the sector to media
          if (data_write) begin
            word_idx <= next_word_idx;
            if (last_word) begin
              busy <= 1'b1;
              data_req <= 1'b0;
              MEDIA_START_OUT <= 1'b1;
              MEDIA_VERIFY_OUT <= verify_mode;
              MEDIA_LBA_MODE_OUT <= drive_head_select[`DH_LBA_BIT];
              MEDIA_ADDR_OUT <= {drive_head_select[3:0], cylinder_high, cylinder_low,
                sector_number};
              state <= S_MEDIA;
            end
          end
        end
        S_MEDIA: begin
          // Done is only believed here, so a stray pulse elsewhere is harmless
          if (MEDIA_DONE_IN) begin
            if (write_err != 8'h00) begin
              // Stop here; address registers left on the failing sector
              error_code <= write_err;
              err_flag <= 1'b1;
              sector_count <= remaining[7:0];
              busy <= 1'b0;
              INTRQ_OUT <= 1'b1;
              state <= S_IDLE;
            end else begin
              remaining <= remaining - 9'h001;
              sector_count <= remaining[7:0] - 8'h01;
              if (last_sector) begin
                // Last sector written: release busy and interrupt
                busy <= 1'b0;
                INTRQ_OUT <= 1'b1;
                state <= S_IDLE;
              end else begin
                // Advance to the next consecutive sector
                sector_number <= step_sec;
                cylinder_low <= step_cyl[7:0];
                cylinder_high <= step_cyl[15:8];
                drive_head_select <= {drive_head_select[7:4], step_head};
                busy <= 1'b0;
                data_req <= 1'b1;
                INTRQ_OUT <= 1'b1;
                word_idx <= {WORD_AW{1'b0}};
                state <= S_XFER;
              end
            end
          end
        end
        S_WAIT: begin
          // Aborted command completes one cycle after its busy flash
          busy <= 1'b0;
          INTRQ_OUT <= 1'b1;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ========================================================
  // Host read data, registered one cycle after the strobe
  always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      HOST_RDATA_OUT <= 16'h0000;
    end else if (CE_IN && HOST_RD_IN) begin
      // Offset 1 shows the error byte; the feature byte is write only
      case (HOST_ADDR_IN)
        `TF_FEATURE_ERROR: HOST_RDATA_OUT <= {8'h00, error_code};
        `TF_SECTOR_COUNT: HOST_RDATA_OUT <= {8'h00, sector_count};
        `TF_SECTOR_NUMBER: HOST_RDATA_OUT <= {8'h00, sector_number};
        `TF_CYLINDER_LOW: HOST_RDATA_OUT <= {8'h00, cylinder_low};
        `TF_CYLINDER_HIGH: HOST_RDATA_OUT <= {8'h00, cylinder_high};
        `TF_DRIVE_HEAD: HOST_RDATA_OUT <= {8'h00, drive_head_select};
        `TF_COMMAND_STATUS: HOST_RDATA_OUT <= {8'h00, device_state};
        default: HOST_RDATA_OUT <= 16'h0000; // Data port is write only here
      endcase
    end
  end
endmodule // ata_sector_write_command_engine

// file: ata_write_engine_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// Port-level checks for the sector-write command engine
module ata_write_engine_checker (
  input wire CLK_SYS_IN,
  input wire RST_B_IN,
  input wire CE_IN,
  input wire [2:0] HOST_ADDR_IN,
  input wire HOST_WR_IN,
  input wire HOST_RD_IN,
  input wire [15:0] HOST_WDATA_IN,
  input wire [15:0] HOST_RDATA_OUT,
  input wire INTRQ_OUT,
  input wire MEDIA_START_OUT,
  input wire MEDIA_VERIFY_OUT,
  input wire MEDIA_LBA_MODE_OUT,
  input wire MEDIA_DONE_IN
);
  reg [7:0] last_cmd;
  reg lba_sel;
  wire cmd_wr = CE_IN && HOST_WR_IN && HOST_ADDR_IN == 3'h7;
  wire code_wr = HOST_WDATA_IN[7:0] == 8'h30 || HOST_WDATA_IN[7:0] == 8'h31 ||
    HOST_WDATA_IN[7:0] == 8'h38 || HOST_WDATA_IN[7:0] == 8'h3C;
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_B_IN);
  // Shadow of the last command and addressing mode; only sound while idle writes
  always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      last_cmd <= 8'h00;
      lba_sel <= 1'b0;
    end else if (cmd_wr) begin
      last_cmd <= HOST_WDATA_IN[7:0];
    end else if (CE_IN && HOST_WR_IN && HOST_ADDR_IN == 3'h6) begin
      lba_sel <= HOST_WDATA_IN[6];
    end
  end
  property p_start_pulse;
    MEDIA_START_OUT |=> !MEDIA_START_OUT [*4];
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  property p_start_cause;
    MEDIA_START_OUT |-> $past(HOST_WR_IN && HOST_ADDR_IN == 3'h0);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without data");
  property p_verify;
    MEDIA_START_OUT |-> MEDIA_VERIFY_OUT == (last_cmd == 8'h3C);
  endproperty
  a_verify: assert property (p_verify) else $error("verify flag wrong");
  property p_lba;
    MEDIA_START_OUT |-> MEDIA_LBA_MODE_OUT == lba_sel;
  endproperty
  a_lba: assert property (p_lba) else $error("addressing mode wrong");
  property p_done_int;
    MEDIA_DONE_IN |=> INTRQ_OUT;
  endproperty
  a_done_int: assert property (p_done_int) else $error("no interrupt after media");
  property p_first_no_int;
    cmd_wr && code_wr |=> !INTRQ_OUT [*2];
  endproperty
  a_first_no_int: assert property (p_first_no_int) else $error("early interrupt");
  property p_abort_int;
    cmd_wr && !code_wr |-> ##[1:3] INTRQ_OUT;
  endproperty
  a_abort_int: assert property (p_abort_int) else $error("abort not signalled");
  property p_rd_zero;
    CE_IN && HOST_RD_IN && HOST_ADDR_IN == 3'h0 |=> HOST_RDATA_OUT == 16'h0000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("data port read not zero");
  property p_rdata_hold;
    !(CE_IN && HOST_RD_IN) |=> $stable(HOST_RDATA_OUT);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule // ata_write_engine_checker

bind ata_sector_write_command_engine ata_write_engine_checker ata_write_engine_checker_inst (
  .CLK_SYS_IN(CLK_SYS_IN), .RST_B_IN(RST_B_IN), .CE_IN(CE_IN), .HOST_ADDR_IN(HOST_ADDR_IN),
  .HOST_WR_IN(HOST_WR_IN), .HOST_RD_IN(HOST_RD_IN), .HOST_WDATA_IN(HOST_WDATA_IN),
  .HOST_RDATA_OUT(HOST_RDATA_OUT), .INTRQ_OUT(INTRQ_OUT), .MEDIA_START_OUT(MEDIA_START_OUT),
  .MEDIA_VERIFY_OUT(MEDIA_VERIFY_OUT), .MEDIA_LBA_MODE_OUT(MEDIA_LBA_MODE_OUT),
  .MEDIA_DONE_IN(MEDIA_DONE_IN));

// file: media_backend_model.sv
`timescale 1ns/1ps
// ==========================================================
// Flash back end: drains the buffer, answers after a delay
module media_backend_model #(
  parameter int WORDS = 4,
  parameter int AW = 2
) (
  input wire clk_in,
  input wire start_in,
  input wire [15:0] data_in,
  input wire [7:0] err_val_in,
  input wire [31:0] err_at_in,
  input wire [7:0] delay_in,
  output logic [AW-1:0] word_out,
  output logic done_out,
  output logic [7:0] error_out,
  output logic [15:0] sum_out,
  output int starts_out
);
  // Error lines show the inverse outside the done cycle, never a stale value
  initial begin
    word_out = '0;
    done_out = 1'b0;
    error_out = 8'hFF;
    sum_out = 16'h0000;
    starts_out = 0;
    forever begin
      @(negedge clk_in);
      if (start_in === 1'b1) begin
        starts_out++;
        sum_out = 16'h0000;
        for (int i = 1; i <= WORDS; i++) begin
          @(negedge clk_in);
          sum_out = sum_out + data_in;
          word_out = AW'(i); // Wraps on the last word, harmless
        end
        repeat (delay_in) @(negedge clk_in);
        done_out = 1'b1;
        error_out = (starts_out == err_at_in) ? err_val_in : 8'h00;
        @(negedge clk_in);
        done_out = 1'b0;
        error_out = ~error_out;
      end
    end
  end
endmodule // media_backend_model

// file: tb.sv
`timescale 1ns/1ps
module tb;
  reg clk = 0, rst_b = 0, wr = 0, rd = 0, ce = 1;
  reg [2:0] addr = 3'h0;
  reg [15:0] wdata = 16'h0000;
  reg [7:0] err_val = 8'h00, dly = 8'h00;
  reg [31:0] err_at = 0;
  wire [15:0] rdata, mdata, sum;
  wire intrq, start, verify, lba, mdone;
  wire [27:0] maddr;
  wire [1:0] mword;
  wire [7:0] merr;
  int starts, n0, k, n_errors = 0, num_checks = 0, cycles = 0;
  reg [15:0] rv, esum;
  reg [27:0] a;
  logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'hA0, 8'h50};
  logic [7:0] codes [4] = '{8'h30, 8'h31, 8'h38, 8'h3C};
  // ==========================================================
  // Clock and cycle ceiling
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles > 40000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // Short sectors keep the 256-sector case quick
  ata_sector_write_command_engine #(.WORDS_PER_SECTOR(4), .WORD_AW(2))
    ata_sector_write_command_engine_inst (
    .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce), .HOST_ADDR_IN(addr), .HOST_WR_IN(wr),
    .HOST_RD_IN(rd), .HOST_WDATA_IN(wdata), .HOST_RDATA_OUT(rdata), .INTRQ_OUT(intrq),
    .MEDIA_START_OUT(start), .MEDIA_VERIFY_OUT(verify), .MEDIA_LBA_MODE_OUT(lba),
    .MEDIA_ADDR_OUT(maddr), .MEDIA_WORD_IN(mword), .MEDIA_DATA_OUT(mdata),
    .MEDIA_DONE_IN(mdone), .MEDIA_ERROR_IN(merr));
  media_backend_model #(.WORDS(4), .AW(2)) media_backend_model_inst (
    .clk_in(clk), .start_in(start), .data_in(mdata), .err_val_in(err_val), .err_at_in(err_at),
    .delay_in(dly), .word_out(mword), .done_out(mdone), .error_out(merr), .sum_out(sum),
    .starts_out(starts));
  // ==========================================================
  // Host access tasks; strobes rise and fall on falling edges
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic hw(input logic [2:0] ad, input logic [15:0] d);
    @(negedge clk);
    wr = 1;
    addr = ad;
    wdata = d;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic hr(input logic [2:0] ad);
    @(negedge clk);
    rd = 1;
    addr = ad;
    @(negedge clk);
    rd = 0;
    rv = rdata;
  endtask
  task automatic wait_int();
    for (int w = 0; w < 3000 && intrq !== 1'b1; w++) @(negedge clk);
  endtask
  function automatic [27:0] nxt(input [27:0] x, input m);
    if (m || x[7:0] < 8'h3F) return x + 28'h000_0001;
    if (x[27:24] < 4'hF) return {x[27:24] + 4'h1, x[23:8], 8'h01};
    return {4'h0, x[23:8] + 16'h0001, 8'h01};
  endfunction
  // One command; ek is the failing sector index, beyond n for none
  task automatic run(input logic [7:0] code, input logic [7:0] cnt, input int n,
    input logic [27:0] s, input logic m, input int ek, input logic [7:0] ev);
    hw(3'h2, {8'h00, cnt});
    hw(3'h3, {8'h00, s[7:0]});
    hw(3'h4, {8'h00, s[15:8]});
    hw(3'h5, {8'h00, s[23:16]});
    hw(3'h6, {8'h00, 1'b1, m, 2'b10, s[27:24]});
    err_at = starts + ek + 1;
    err_val = ev;
    a = s;
    // Command write, then a status read on the very next edge to catch busy
    @(negedge clk);
    wr = 1;
    addr = 3'h7;
    wdata = {8'h00, code};
    @(negedge clk);
    wr = 0;
    rd = 1;
    @(negedge clk);
    rd = 0;
    chk("status_accept", 8'hD0, rdata);
    chk("intrq_first", 0, intrq);
    rv = 16'h0000;
    for (int p = 0; p < 50 && rv[3] !== 1'b1; p++) hr(3'h7);
    for (int sk = 0; sk < n; sk++) begin
      if (sk > 0) begin
        wait_int();
        chk("intrq_next", 1, intrq);
        hr(3'h7);
        chk("status_next", 8'h58, rv);
      end
      esum = 16'h0000;
      for (int si = 0; si < 4; si++) begin
        hw(3'h0, {sk[7:0] ^ 8'hA5, si[7:0]});
        esum = esum + wdata;
      end
      chk("start", 1, start);
      chk("media_addr", a, maddr);
      chk("verify", code == 8'h3C, verify);
      chk("lba_mode", m, lba);
      hr(3'h7);
      chk("status_busy", 8'hD0, rv);
      if (sk == ek) break;
      a = nxt(a, m);
    end
    wait_int();
    chk("intrq_end", 1, intrq);
    chk("data_sum", esum, sum);
    hr(3'h7);
    chk("status_end", (ek < n) ? 8'h51 : 8'h50, rv);
    hr(3'h1);
    chk("error", (ek < n) ? (ev & 8'h95) : 8'h00, rv);
    hr(3'h2);
    chk("residual", (ek < n) ? n - ek : 0, rv);
    if (ek < n) begin
      hr(3'h3);
      chk("fail_sector", a[7:0], rv);
      hr(3'h6);
      chk("fail_head", {1'b1, m, 2'b10, a[27:24]}, rv);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1;
    // Reset values and the data port reading zero
    for (k = 0; k < 8; k++) begin
      hr(k[2:0]);
      chk("reset_reg", rst_tab[k], rv);
    end
    // Clock enable low: a register write is frozen out
    ce = 0;
    hw(3'h3, 16'h0077);
    ce = 1;
    hr(3'h3);
    chk("frozen_write", 8'h01, rv);
    // Unknown code aborts with only the aborted error
    hw(3'h7, 16'h0020);
    wait_int();
    chk("abort_intrq", 1, intrq);
    hr(3'h7);
    chk("abort_status", 8'h51, rv);
    hr(3'h1);
    chk("abort_error", 8'h04, rv);
    // Every write code, two sectors across a byte carry, slow media
    dly = 8'h14;
    for (k = 0; k < 4; k++) run(codes[k], 8'h02, 2, 28'h534_12FF, 1'b1, 99, 8'h00);
    // Error on the second of three, track wrap, then reissue from there
    dly = 8'h00;
    n0 = starts;
    run(8'h31, 8'h03, 3, 28'h201_003F, 1'b0, 1, 8'hD5);
    chk("starts_on_error", n0 + 2, starts);
    run(8'h31, 8'h02, 2, 28'h301_0001, 1'b0, 99, 8'h00);
    // Zero count asks for 256 sectors
    n0 = starts;
    run(8'h30, 8'h00, 256, 28'h000_0001, 1'b0, 999, 8'h00);
    chk("starts_256", n0 + 256, starts);
    report_and_stop();
  end
endmodule // tb
